//--- dsf_top.sv
`timescale 1ns/100ps
module dsf_top #(
    parameter int SEC_CYCLES = dsf_pkg::SEC_CYC,
    parameter int SEEK_CYCLES = dsf_pkg::SEEK_CYC,
    parameter logic [27:0] MAX_LBA = 28'hfffffff,
    parameter logic [15:0] MAX_CYL = 16'hffff
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic I_SOFT_RST,
    input wire logic I_REASSIGN_FULL,
    input wire dsf_pkg::dsf_bus_t I_BUS,
    output logic [7:0] O_RDATA,
    output dsf_pkg::dsf_ctrl_t O_CTRL
);
    import dsf_pkg::*;

    typedef struct packed {
        dsf_cs_t cs;
        logic [7:0] feat;
        logic [7:0] scnt;
        logic [7:0] snum;
        logic [7:0] cyll;
        logic [7:0] cylh;
        logic [7:0] devh;
        logic [7:0] err;
        logic [7:0] rdata;
        logic [7:0] xfer;
        logic [7:0] apm_lvl;
        logic [7:0] aam_lvl;
        logic seek_complete_flag;
        logic wc_en;
        logic wc_eff;
        logic rla_en;
        logic ecc52;
        logic rev_en;
        logic rel_en;
        logic apm_en;
        logic y1_set;
        logic puis_en;
        logic aofs_en;
        logic aam_en;
        logic aam_q;
        logic spinup;
        logic seek_go;
        logic lba;
        dsf_ps_t deep;
        dsf_ps_t pwr;
        logic [8:0] y1;
        logic [12:0] y2;
        logic [12:0] idle_s;
        logic [15:0] busy;
        logic [31:0] tick;
        logic [27:0] pos;
    } dsf_state_t;

    dsf_state_t s;
    dsf_state_t next_s;
    logic cmd;
    logic [27:0] tgt;

    function automatic logic xfer_ok(input logic [7:0] v);
        case (v[7:3])
            XT_PIO: xfer_ok = v[2:0] <= XM_PIO;
            XT_PIOFC: xfer_ok = v[2:0] <= XM_PIOFC;
            XT_MDMA: xfer_ok = v[2:0] <= XM_MDMA;
            XT_UDMA: xfer_ok = v[2:0] <= XM_UDMA;
            default: xfer_ok = 1'b0;
        endcase
    endfunction : xfer_ok

    function automatic logic feat_known(input logic [7:0] f);
        case (f)
            F_WC_ON, F_XFER, F_APM_ON, F_PUIS_ON, F_SPINUP, F_AOFS_ON,
            F_AAM_ON, F_ECC52, F_REL_ON, F_REV_OFF, F_WC_OFF, F_APM_OFF,
            F_PUIS_OFF, F_AOFS_OFF, F_RLA_ON, F_ECC4, F_AAM_OFF,
            F_REV_ON: feat_known = 1'b1;
            default: feat_known = 1'b0;
        endcase
    endfunction : feat_known

    function automatic logic [8:0] y1_of(input logic [7:0] lvl);
        y1_of = 9'(Y1_BASE_S + int'(lvl - LVL_LPI) * Y1_STEP_S);
    endfunction : y1_of

    function automatic logic [12:0] y2_of(input logic [7:0] lvl);
        y2_of = 13'(Y2_BASE_S + int'(lvl - LVL_STBY) * Y2_STEP_S);
    endfunction : y2_of

    // Feature and power defaults, shared by hard and reverting soft reset
    function automatic dsf_state_t dflt(input dsf_state_t v);
        dsf_state_t r;
        r = v;
        r.cs = CS_IDLE;
        r.err = '0;
        r.seek_complete_flag = 1'b1;
        r.busy = '0;
        r.wc_en = 1'b1;
        r.rla_en = 1'b1;
        r.ecc52 = 1'b0;
        r.rev_en = 1'b0;
        r.rel_en = 1'b0;
        r.xfer = XFER_DFLT;
        r.apm_en = 1'b0;
        r.y1_set = 1'b0;
        r.deep = PS_ACTIVE;
        r.pwr = PS_ACTIVE;
        r.y1 = 9'(Y1_BASE_S);
        r.y2 = 13'(Y2_BASE_S);
        dflt = r;
    endfunction : dflt

    assign cmd = I_BUS.wr && I_BUS.addr == A_CMD && s.cs == CS_IDLE;
    assign tgt = {s.devh[3:0], s.cylh, s.cyll, s.snum};

    always_comb begin
        next_s = s;
        next_s.rdata = '0;
        next_s.spinup = 1'b0;
        next_s.seek_go = 1'b0;
        // One-second idle timer
        if (s.tick >= 32'(SEC_CYCLES - 1)) begin
            next_s.tick = '0;
            if (s.idle_s != '1) begin
                next_s.idle_s = s.idle_s + 13'h1;
            end
        end else begin
            next_s.tick = s.tick + 32'h1;
        end
        if (s.apm_en) begin
            if (s.deep == PS_STBY && s.idle_s >= s.y2) begin
                next_s.pwr = PS_STBY;
            end else if (s.deep != PS_ACTIVE && s.idle_s >= 13'(s.y1)) begin
                next_s.pwr = PS_LPI;
            end
        end
        if (I_BUS.wr) begin
            case (I_BUS.addr)
                A_FEAT: next_s.feat = I_BUS.wdata;
                A_SCNT: next_s.scnt = I_BUS.wdata;
                A_SNUM: next_s.snum = I_BUS.wdata;
                A_CYLL: next_s.cyll = I_BUS.wdata;
                A_CYLH: next_s.cylh = I_BUS.wdata;
                A_DEVH: next_s.devh = I_BUS.wdata;
                default: ;
            endcase
        end
        if (I_BUS.rd) begin
            case (I_BUS.addr)
                A_FEAT: next_s.rdata = s.err;
                A_SCNT: next_s.rdata = s.scnt;
                A_SNUM: next_s.rdata = s.snum;
                A_CYLL: next_s.rdata = s.cyll;
                A_CYLH: next_s.rdata = s.cylh;
                A_DEVH: next_s.rdata = s.devh;
                A_CMD: begin
                    next_s.rdata[ST_BSY] = s.cs == CS_SEEK;
                    next_s.rdata[ST_RDY] = 1'b1;
                    next_s.rdata[ST_DSC] = s.seek_complete_flag;
                    next_s.rdata[ST_ERR] = s.err != '0;
                end
                A_CFG: next_s.rdata = {s.rev_en, s.rel_en, s.ecc52, s.rla_en,
                                       s.wc_eff, s.aofs_en, s.puis_en, s.aam_en};
                A_APM: next_s.rdata = s.apm_lvl;
                A_XFER: next_s.rdata = s.xfer;
                A_AAM: next_s.rdata = s.aam_lvl;
                A_PST: next_s.rdata = {s.apm_en, s.aam_q, s.deep[1:0],
                                       1'b0, s.pwr};
                default: next_s.rdata = '0;
            endcase
        end
        if (cmd) begin
            next_s.tick = '0;
            next_s.idle_s = '0;
            next_s.pwr = PS_ACTIVE;
            next_s.err = '0;
            if (I_BUS.wdata[7:4] == CMD_SEEK_NIB) begin
                // No format check gates the seek
                if (s.devh[DH_LBA] ? tgt > MAX_LBA : {s.cylh, s.cyll} > MAX_CYL) begin
                    next_s.err[ERR_IDN] = 1'b1;
                    next_s.err[ERR_ABT] = 1'b1;
                end else begin
                    next_s.cs = CS_SEEK;
                    next_s.busy = 16'(SEEK_CYCLES);
                    next_s.seek_complete_flag = 1'b0;
                    next_s.seek_go = 1'b1;
                    next_s.lba = s.devh[DH_LBA];
                    next_s.pos = tgt;
                end
            end else if (I_BUS.wdata == CMD_SETF) begin
                if (!feat_known(s.feat)) begin
                    next_s.err[ERR_ABT] = 1'b1;
                end
                case (s.feat)
                    F_WC_ON: next_s.wc_en = 1'b1;
                    F_WC_OFF: next_s.wc_en = 1'b0;
                    F_RLA_ON: next_s.rla_en = 1'b1;
                    F_XFER: begin
                        if (xfer_ok(s.scnt)) begin
                            next_s.xfer = s.scnt;
                        end else begin
                            next_s.err[ERR_ABT] = 1'b1;
                        end
                    end
                    F_APM_ON: begin
                        if (s.scnt == LVL_NONE || s.scnt == LVL_FULL) begin
                            next_s.err[ERR_ABT] = 1'b1;
                        end else begin
                            next_s.apm_en = 1'b1;
                            next_s.apm_lvl = s.scnt;
                            if (s.scnt >= LVL_NORM) begin
                                next_s.deep = PS_ACTIVE;
                                next_s.y1_set = 1'b0;
                            end else if (s.scnt >= LVL_LPI) begin
                                next_s.deep = PS_LPI;
                                next_s.y1 = y1_of(s.scnt);
                                next_s.y1_set = 1'b1;
                            end else begin
                                next_s.deep = PS_STBY;
                                next_s.y1_set = 1'b1;
                                if (!s.y1_set) begin
                                    next_s.y1 = 9'(Y1_BASE_S);
                                end
                                if (s.scnt >= LVL_STBY) begin
                                    next_s.y2 = y2_of(s.scnt);
                                end else begin
                                    next_s.y2 = 13'(Y2_BASE_S);
                                end
                            end
                        end
                    end
                    F_APM_OFF: begin
                        next_s.apm_en = 1'b0;
                        next_s.deep = PS_ACTIVE;
                        next_s.y1_set = 1'b0;
                    end
                    F_PUIS_ON: next_s.puis_en = 1'b1;
                    F_PUIS_OFF: next_s.puis_en = 1'b0;
                    F_SPINUP: next_s.spinup = s.puis_en;
                    F_AOFS_ON: next_s.aofs_en = 1'b1;
                    F_AOFS_OFF: next_s.aofs_en = 1'b0;
                    F_AAM_ON: begin
                        if (s.scnt < LVL_LPI || s.scnt == LVL_FULL) begin
                            next_s.err[ERR_ABT] = 1'b1;
                        end else begin
                            next_s.aam_en = 1'b1;
                            next_s.aam_lvl = s.scnt;
                            next_s.aam_q = s.scnt < LVL_NORM;
                        end
                    end
                    F_AAM_OFF: next_s.aam_en = 1'b0;
                    F_ECC52: next_s.ecc52 = 1'b1;
                    F_ECC4: next_s.ecc52 = 1'b0;
                    F_REV_OFF: next_s.rev_en = 1'b0;
                    F_REV_ON: next_s.rev_en = 1'b1;
                    F_REL_ON: next_s.rel_en = 1'b1;
                    default: ;
                endcase
            end else begin
                next_s.err[ERR_ABT] = 1'b1;
            end
        end
        // Seek in progress
        if (s.cs == CS_SEEK) begin
            if (s.busy <= 16'h1) begin
                next_s.cs = CS_IDLE;
                next_s.seek_complete_flag = 1'b1;
                if (s.lba) begin
                    next_s.snum = s.pos[7:0];
                    next_s.cyll = s.pos[15:8];
                    next_s.cylh = s.pos[23:16];
                    next_s.devh[3:0] = s.pos[27:24];
                end
            end else begin
                next_s.busy = s.busy - 16'h1;
            end
        end
        if (I_SOFT_RST) begin
            next_s.cs = CS_IDLE;
            next_s.seek_complete_flag = 1'b1;
            next_s.err = '0;
            if (s.rev_en) begin
                next_s = dflt(next_s);
            end
        end
        next_s.wc_eff = next_s.wc_en && !I_REASSIGN_FULL;
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            s <= dflt(dsf_state_t'('0));
        end else begin
            s <= next_s;
        end
    end

    assign O_RDATA = s.rdata;
    assign O_CTRL = '{
        wcache_on: s.wc_eff,
        rla_on: s.rla_en,
        ecc52: s.ecc52,
        rel_int_on: s.rel_en,
        puis_on: s.puis_en,
        spinup: s.spinup,
        aofs_on: s.aofs_en,
        aam_on: s.aam_en,
        aam_quiet: s.aam_q,
        apm_on: s.apm_en,
        pwr: s.pwr,
        seek_go: s.seek_go,
        lba_mode: s.lba,
        xfer: s.xfer,
        pos: s.pos
    };

    localparam int SEEK_BND = SEEK_CYCLES + 1;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RST);

    sequence seek_req_s;
        cmd && I_BUS.wdata[7:4] == CMD_SEEK_NIB && !I_SOFT_RST;
    endsequence

    sequence setf_s(logic [7:0] f);
        cmd && I_BUS.wdata == CMD_SETF && s.feat == f && !I_SOFT_RST;
    endsequence

    chk_seek_start: assert property (seek_req_s ##0 !next_s.err[ERR_IDN]
        |=> O_CTRL.seek_go && s.cs == CS_SEEK && !s.seek_complete_flag)
        else $error("seek did not start");
    chk_seek_done: assert property (seek_req_s ##0 !next_s.err[ERR_IDN]
        |=> !s.seek_complete_flag ##[1:SEEK_BND] s.seek_complete_flag)
        else $error("seek did not complete");
    chk_lba_readback: assert property ($fell(s.cs == CS_SEEK) && s.lba && !$past(I_SOFT_RST)
        |-> {s.devh[3:0], s.cylh, s.cyll, s.snum} == O_CTRL.pos)
        else $error("current lba not returned");
    chk_bad_feat_abt: assert property (cmd && I_BUS.wdata == CMD_SETF
        && !feat_known(s.feat) && !I_SOFT_RST |=> s.err[ERR_ABT])
        else $error("undefined feature not aborted");
    chk_xfer_set: assert property (setf_s(F_XFER) ##0 xfer_ok(s.scnt)
        |=> s.xfer == $past(s.scnt) && !s.err[ERR_ABT])
        else $error("transfer mode not taken");
    chk_wc_forced_off: assert property (I_REASSIGN_FULL && !I_SOFT_RST
        |=> !O_CTRL.wcache_on)
        else $error("write cache on with reassign space full");
    chk_apm_abort: assert property (setf_s(F_APM_ON)
        ##0 (s.scnt == LVL_NONE || s.scnt == LVL_FULL)
        |=> s.err[ERR_ABT] && $stable(s.apm_en))
        else $error("bad power level not aborted");
    chk_lpi_time: assert property (setf_s(F_APM_ON)
        ##0 (s.scnt >= LVL_LPI && s.scnt < LVL_NORM)
        |=> s.y1 == y1_of($past(s.scnt)) && s.deep == PS_LPI)
        else $error("low power idle time wrong");
    chk_apm_off: assert property (setf_s(F_APM_OFF)
        |=> s.deep == PS_ACTIVE && !O_CTRL.apm_on)
        else $error("power management not disabled");
    chk_reset_dflt: assert property (@(posedge I_CORE_CLK) disable iff (1'b0)
        I_RST |=> O_CTRL.rla_on && !O_CTRL.ecc52 && !s.rev_en
        && !O_CTRL.rel_int_on && s.wc_en)
        else $error("reset defaults wrong");
endmodule : dsf_top

//--- dsf_pkg.sv
package dsf_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 200;
    localparam int SEEK_TIME_NS = 1000;
    localparam int SEEK_CYC = (SEEK_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int SEC_TIME_MS = 1000;
    localparam int SEC_CYC = SEC_TIME_MS * CLK_MHZ * 1000;

    // Register offsets
    localparam logic [3:0] A_FEAT = 4'h1;
    localparam logic [3:0] A_SCNT = 4'h2;
    localparam logic [3:0] A_SNUM = 4'h3;
    localparam logic [3:0] A_CYLL = 4'h4;
    localparam logic [3:0] A_CYLH = 4'h5;
    localparam logic [3:0] A_DEVH = 4'h6;
    localparam logic [3:0] A_CMD = 4'h7;
    localparam logic [3:0] A_CFG = 4'h8;
    localparam logic [3:0] A_APM = 4'h9;
    localparam logic [3:0] A_XFER = 4'ha;
    localparam logic [3:0] A_AAM = 4'hb;
    localparam logic [3:0] A_PST = 4'hc;

    // Commands and feature codes
    localparam logic [3:0] CMD_SEEK_NIB = 4'h7;
    localparam logic [7:0] CMD_SETF = 8'hef;
    localparam logic [7:0] F_WC_ON = 8'h02;
    localparam logic [7:0] F_XFER = 8'h03;
    localparam logic [7:0] F_APM_ON = 8'h05;
    localparam logic [7:0] F_PUIS_ON = 8'h06;
    localparam logic [7:0] F_SPINUP = 8'h07;
    localparam logic [7:0] F_AOFS_ON = 8'h09;
    localparam logic [7:0] F_AAM_ON = 8'h42;
    localparam logic [7:0] F_ECC52 = 8'h44;
    localparam logic [7:0] F_REL_ON = 8'h5d;
    localparam logic [7:0] F_REV_OFF = 8'h66;
    localparam logic [7:0] F_WC_OFF = 8'h82;
    localparam logic [7:0] F_APM_OFF = 8'h85;
    localparam logic [7:0] F_PUIS_OFF = 8'h86;
    localparam logic [7:0] F_AOFS_OFF = 8'h89;
    localparam logic [7:0] F_RLA_ON = 8'haa;
    localparam logic [7:0] F_ECC4 = 8'hbb;
    localparam logic [7:0] F_AAM_OFF = 8'hc2;
    localparam logic [7:0] F_REV_ON = 8'hcc;

    // Bit positions
    localparam int ERR_ABT = 2;
    localparam int ERR_IDN = 4;
    localparam int ST_BSY = 7;
    localparam int ST_RDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_ERR = 0;
    localparam int DH_LBA = 6;

    // Level bounds and idle times in seconds
    localparam logic [7:0] LVL_NONE = 8'h00;
    localparam logic [7:0] LVL_FULL = 8'hff;
    localparam logic [7:0] LVL_NORM = 8'hc0;
    localparam logic [7:0] LVL_LPI = 8'h80;
    localparam logic [7:0] LVL_STBY = 8'h40;
    localparam int Y1_BASE_S = 120;
    localparam int Y1_STEP_S = 5;
    localparam int Y2_BASE_S = 600;
    localparam int Y2_STEP_S = 60;

    // Transfer types and highest mode numbers
    localparam logic [4:0] XT_PIO = 5'h00;
    localparam logic [4:0] XT_PIOFC = 5'h01;
    localparam logic [4:0] XT_MDMA = 5'h04;
    localparam logic [4:0] XT_UDMA = 5'h08;
    localparam logic [2:0] XM_PIO = 3'h1;
    localparam logic [2:0] XM_PIOFC = 3'h4;
    localparam logic [2:0] XM_MDMA = 3'h2;
    localparam logic [2:0] XM_UDMA = 3'h5;
    localparam logic [7:0] XFER_DFLT = 8'h00;

    typedef enum logic [1:0] {
        CS_IDLE = 2'b01,
        CS_SEEK = 2'b10
    } dsf_cs_t;

    typedef enum logic [2:0] {
        PS_ACTIVE = 3'b001,
        PS_LPI = 3'b010,
        PS_STBY = 3'b100
    } dsf_ps_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [3:0] addr;
        logic [7:0] wdata;
    } dsf_bus_t;

    typedef struct packed {
        logic wcache_on;
        logic rla_on;
        logic ecc52;
        logic rel_int_on;
        logic puis_on;
        logic spinup;
        logic aofs_on;
        logic aam_on;
        logic aam_quiet;
        logic apm_on;
        dsf_ps_t pwr;
        logic seek_go;
        logic lba_mode;
        logic [7:0] xfer;
        logic [27:0] pos;
    } dsf_ctrl_t;
endpackage : dsf_pkg

//--- dsf_host.sv
`timescale 1ns/100ps
module dsf_host
    import dsf_pkg::*;
(
    input wire logic i_clk,
    input wire logic [7:0] i_rdata,
    output dsf_pkg::dsf_bus_t o_bus
);
    initial o_bus = '0;
    // Write strobe for one cycle; released fields are scrambled
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge i_clk);
        o_bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr
    // Read data is taken in the cycle after the strobe only
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge i_clk);
        o_bus <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        @(posedge i_clk);
        d = i_rdata;
    endtask : rd
endmodule : dsf_host

//--- dsf_top_bench.sv
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("Error at %0t ns: got %h expected %h", $time, g, e); end end
module dsf_top_bench;
    import dsf_pkg::*;
    localparam int SEC = 10;
    localparam int SEEK = 4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic soft_rst = 1'b0;
    logic full = 1'b0;
    dsf_bus_t bus;
    logic [7:0] rdata;
    dsf_ctrl_t ctrl;
    logic [7:0] v;
    logic [7:0] last = 8'h00;
    int failures = 0;
    int n_checks = 0;
    int spins = 0;
    int seeks = 0;
    logic [7:0] fcode [13] = '{8'h82, 8'h02, 8'h44, 8'hbb, 8'h5d, 8'hcc, 8'h66,
        8'h06, 8'h07, 8'h86, 8'h09, 8'h89, 8'haa};
    logic [7:0] fcfg [13] = '{8'h10, 8'h18, 8'h38, 8'h18, 8'h58, 8'hd8, 8'h58,
        8'h5a, 8'h5a, 8'h58, 8'h5c, 8'h58, 8'h58};
    logic [7:0] xv [9] = '{8'h00, 8'h01, 8'h02, 8'h0c, 8'h0d, 8'h22, 8'h23, 8'h45, 8'h10};
    logic xok [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (ctrl.spinup === 1'b1)
            spins++;
        if (ctrl.seek_go === 1'b1)
            seeks++;
    end

    dsf_host host_u (.i_clk(clk), .i_rdata(rdata), .o_bus(bus));
    dsf_top #(.SEC_CYCLES(SEC), .SEEK_CYCLES(SEEK)) dut_u (
        .I_CORE_CLK(clk), .I_RST(rst), .I_SOFT_RST(soft_rst), .I_REASSIGN_FULL(full),
        .I_BUS(bus), .O_RDATA(rdata), .O_CTRL(ctrl));

    task automatic rc(input logic [3:0] a, input logic [7:0] e);
        host_u.rd(a, v);
        `CHK(v, e)
    endtask : rc
    task automatic setf(input logic [7:0] f, input logic [7:0] s);
        host_u.wr(A_SCNT, s);
        host_u.wr(A_FEAT, f);
        host_u.wr(A_CMD, CMD_SETF);
        @(posedge clk);
    endtask : setf
    task automatic seek(input logic [7:0] sn, input logic [15:0] cy, input logic [7:0] dh);
        host_u.wr(A_SNUM, sn);
        host_u.wr(A_CYLL, cy[7:0]);
        host_u.wr(A_CYLH, cy[15:8]);
        host_u.wr(A_DEVH, dh);
        host_u.wr(A_CMD, 8'h7b);
        host_u.wr(A_SNUM, ~sn);
        rc(A_CMD, 8'hc0);
        repeat (SEEK + 2) @(posedge clk);
        rc(A_CMD, 8'h50);
    endtask : seek
    task automatic idle_s(input int s);
        repeat (s * SEC) @(posedge clk);
        #1;
    endtask : idle_s
    task automatic wait_pwr(input dsf_ps_t p, input int n);
        for (int i = 0; i < n && ctrl.pwr !== p; i++) begin
            @(posedge clk);
            #1;
        end
        `CHK(ctrl.pwr, p)
    endtask : wait_pwr
    task automatic pulse(input bit hard);
        @(posedge clk);
        if (hard)
            rst <= 1'b1;
        else
            soft_rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        soft_rst <= 1'b0;
        @(posedge clk);
    endtask : pulse
    task automatic close_out();
        $display("Checks %0d, failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : close_out

    initial begin
        #200000;
        failures++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rc(A_CFG, 8'h18);
        rc(A_CMD, 8'h50);
        for (int i = 0; i < 13; i++) begin
            setf(fcode[i], 8'h00);
            rc(A_CFG, fcfg[i]);
            rc(A_FEAT, 8'h00);
        end
        `CHK({ctrl.rla_on, ctrl.ecc52, ctrl.rel_int_on, ctrl.puis_on, ctrl.aofs_on}, 5'b10100)
        setf(F_SPINUP, 8'h00);
        @(posedge clk);
        `CHK(spins, 1)
        setf(8'h55, 8'h00);
        rc(A_FEAT, 8'h04);
        rc(A_CMD, 8'h51);
        for (int i = 0; i < 9; i++) begin
            setf(F_XFER, xv[i]);
            if (xok[i])
                last = xv[i];
            rc(A_XFER, last);
            rc(A_FEAT, xok[i] ? 8'h00 : 8'h04);
        end
        `CHK(ctrl.xfer, last)
        setf(F_AAM_ON, 8'h7f);
        rc(A_FEAT, 8'h04);
        setf(F_AAM_ON, 8'hc0);
        `CHK({ctrl.aam_on, ctrl.aam_quiet}, 2'b10)
        setf(F_AAM_OFF, 8'h00);
        `CHK(ctrl.aam_on, 1'b0)
        setf(F_AAM_ON, 8'h80);
        `CHK({ctrl.aam_on, ctrl.aam_quiet}, 2'b11)
        rc(A_AAM, 8'h80);
        full <= 1'b1;
        setf(F_WC_ON, 8'h00);
        rc(A_FEAT, 8'h00);
        `CHK(ctrl.wcache_on, 1'b0)
        full <= 1'b0;
        setf(F_APM_ON, 8'hff);
        rc(A_FEAT, 8'h04);
        setf(F_APM_ON, 8'h00);
        rc(A_FEAT, 8'h04);
        setf(F_APM_ON, 8'h81);
        idle_s(124);
        `CHK(ctrl.pwr, PS_ACTIVE)
        wait_pwr(PS_LPI, 20);
        idle_s(575);
        `CHK(ctrl.pwr, PS_LPI)
        `CHK(ctrl.apm_on, 1'b1)
        setf(F_APM_ON, 8'h41);
        idle_s(124);
        `CHK(ctrl.pwr, PS_ACTIVE)
        wait_pwr(PS_LPI, 20);
        idle_s(534);
        `CHK(ctrl.pwr, PS_LPI)
        wait_pwr(PS_STBY, 40);
        setf(F_APM_OFF, 8'h00);
        idle_s(200);
        `CHK({ctrl.apm_on, ctrl.pwr}, {1'b0, PS_ACTIVE})
        setf(F_APM_ON, 8'h3f);
        idle_s(119);
        `CHK(ctrl.pwr, PS_ACTIVE)
        wait_pwr(PS_LPI, 20);
        idle_s(478);
        `CHK(ctrl.pwr, PS_LPI)
        wait_pwr(PS_STBY, 40);
        setf(F_APM_ON, 8'h90);
        pulse(1'b0);
        `CHK(ctrl.apm_on, 1'b1)
        rc(A_CFG, 8'h59);
        setf(F_REV_ON, 8'h00);
        pulse(1'b0);
        `CHK({ctrl.apm_on, ctrl.aam_on}, 2'b01)
        rc(A_CFG, 8'h19);
        seek(8'h12, 16'h5634, 8'he7);
        `CHK({ctrl.lba_mode, ctrl.pos}, {1'b1, 28'h7563412})
        rc(A_SNUM, 8'h12);
        rc(A_CYLL, 8'h34);
        rc(A_CYLH, 8'h56);
        host_u.rd(A_DEVH, v);
        `CHK(v[3:0], 4'h7)
        seek(8'h01, 16'h0123, 8'ha3);
        rc(A_FEAT, 8'h00);
        `CHK({ctrl.lba_mode, seeks}, {1'b0, 32'd2})
        pulse(1'b1);
        rc(A_CFG, 8'h18);
        close_out();
    end
endmodule : dsf_top_bench
